// >>> common/acs_params.svh
/*
 Constants of the conversion sequencer: command fields, reset values, timing.
 Assumes inclusion by the sequencer and its serial link, after acs_pkg.
*/
// Overview of operation
// RQ1 - Byte 0001xxxx is the reset command
// RQ2 - Reset bit3 low: all registers; high: FIFO
// RQ3 - Mode 00: start pulse runs whole scan
// RQ4 - Mode 00: scan done drives EOC low
// RQ5 - Mode 00: host waits EOC before next start
// RQ6 - Temperature result enters FIFO before channels
// RQ7 - Mode 01: host holds start low long enough
// RQ8 - Mode 01: rising start runs one conversion
// RQ9 - Mode 01: host waits EOC before next edge
// RQ10 - Mode 01: averaging counts pulses, then advances channel
// RQ11 - Mode 01: temperature on first rising start
// RQ12 - Mode 10: conversion byte runs whole scan
// RQ13 - Mode 11: SCLK-timed single result on DOUT
// RQ14 - Mode 11: short select pulse keeps conversion
// RQ15 - Mode 11: zero byte between conversion bytes
// RQ16 - Mode 11: host waits for reference wake
// RQ17 - Mode 11: temperature in last two of 24 bytes
// RQ18 - Partial first byte: next read gives low byte; the code resumes at the first bit not yet read
// RQ19 - Partial second byte drops rest of entry
// RQ20 - Partial write updates only bits shifted in
// RQ21 - Host keeps select high until EOC low
// RQ22 - Power-up registers zero, setup in mode 10
// RQ23 - Results: 16 bits, MSB first, zero-led
// RQ24 - DIN taken on rising, DOUT on falling
// RQ25 - Sixteen-entry FIFO read in write order
`ifndef ACS_PARAMS_SVH
`define ACS_PARAMS_SVH
`define ACS_REG_RESET 8'h00
`define ACS_SETUP_RESET 8'h20
`define ACS_CLK_NS 25
`define ACS_T_REF_WAKE_US 65
`define ACS_REF_WAKE_CYC ((`ACS_T_REF_WAKE_US * 1000 + `ACS_CLK_NS - 1) / `ACS_CLK_NS)
`define ACS_MODE_CNV_SCAN 2'b00
`define ACS_MODE_CNV_ONE 2'b01
`define ACS_MODE_SER_SCAN 2'b10
`define ACS_MODE_SER_CLK 2'b11
`define ACS_REF_AUTO 2'b00
`define ACS_RST_FIFO_BIT 3
`define ACS_CLOCK_MODE_SELECT 5:4
`define ACS_REFERENCE_MODE_FIELD 3:2
`define ACS_DIFFSEL 1:0
`define ACS_CH 6:3
`define ACS_SCAN 2:1
`define ACS_TEMP_BIT 0
`define ACS_AVGON_BIT 4
`define ACS_NAVG 3:2
`define ACS_NSCAN 1:0
`define ACS_BYTE_BITS 8
`define ACS_ENTRY_BITS 16
`define ACS_TEMP_BITS 192
`endif

// >>> common/acs_pkg.sv
/*
 Types shared by the conversion sequencer and its serial link.
 Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package acs_pkg;
    typedef enum logic [1:0] {ACS_IDLE, ACS_WAKE, ACS_CONV} acs_seq_type;
    typedef enum logic [2:0] {ACS_CMD_NONE, ACS_CMD_CONV, ACS_CMD_SETUP, ACS_CMD_AVG, ACS_CMD_RESET} acs_cmd_type;
    typedef struct packed {
        logic [15:0] word0;
        logic [15:0] word1;
        logic [15:0] direct;
        logic [15:0] temp;
        logic [4:0] start_bit;
        logic [1:0] mode;
    } acs_tx_type;
    typedef struct packed {
        logic [7:0] rx_byte;
        logic rx_tgl;
        logic [7:0] rx_part;
        logic [2:0] rx_count;
        logic [5:0] tx_count;
        logic frame_tgl;
    } acs_rx_type;
    typedef struct packed {
        logic [7:0] shr;
        logic [2:0] bitc;
        logic [7:0] byte_q;
        logic tgl;
        logic ftgl;
        logic [5:0] txc;
        logic m11_on;
        logic m11_tmp;
        logic [7:0] m11c;
    } acs_link_type;
endpackage
`default_nettype wire

// >>> hdl/acs_serial_link.sv
/*
 Serial link on the SCLK domain: byte assembly, bit counts, DOUT shifting.
 Assumes SCLK stands still while chip select is high; words in tx are stable
 for the whole frame; the system side reads rx counts only after the frame.
*/
`timescale 1ns/1ps
`default_nettype none
`include "acs_params.svh"
module acs_serial_link (
    input wire logic sclk, // Link clock
    input wire logic resetn, // Asynchronous reset
    input wire logic cs_n, // Chip select, ends a frame when high
    input wire logic din, // Serial data in
    output logic dout, // Serial data out
    input wire acs_pkg::acs_tx_type tx, // Words to shift out
    output acs_pkg::acs_rx_type rx // Bytes and counts received
);
    acs_pkg::acs_link_type s;
    acs_pkg::acs_link_type n;
    acs_pkg::acs_link_type cp;
    logic live;
    logic q;
    logic [2:0] bc;
    logic [5:0] tc;

    function automatic logic pick(acs_pkg::acs_link_type st, acs_pkg::acs_tx_type t);
        logic [6:0] p;
        logic [7:0] k;
        logic [31:0] w;
        p = 7'(t.start_bit) + 7'(st.txc);
        k = st.m11c - 8'(`ACS_TEMP_BITS - `ACS_ENTRY_BITS);
        w = {t.word0, t.word1};
        if (st.m11_on && st.m11_tmp) begin
            pick = (st.m11c >= 8'(`ACS_TEMP_BITS - `ACS_ENTRY_BITS)) ? t.temp[4'd15 - k[3:0]] : 1'b0;
        end else if (st.m11_on) begin
            pick = t.direct[4'd15 - st.m11c[3:0]];
        end else begin
            pick = (p < 7'(2 * `ACS_ENTRY_BITS)) ? w[5'd31 - p[4:0]] : 1'b0;
        end
    endfunction

    // Cleared by chip select so the first edge of a frame restarts counts
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            live <= 1'b0;
        end else begin
            live <= 1'b1;
        end
    end

    always_comb begin
        n = s;
        bc = live ? s.bitc : 3'd0;
        tc = live ? s.txc : 6'd0;
        if (!live) begin
            n.ftgl = ~s.ftgl;
        end
        n.shr = {s.shr[6:0], din}; // RQ24
        n.bitc = bc + 3'd1;
        n.txc = (tc == 6'h3F) ? tc : tc + 6'd1;
        if (s.m11_on) begin
            n.m11c = s.m11c + 8'd1;
            if (s.m11c == (s.m11_tmp ? 8'(`ACS_TEMP_BITS - 1) : 8'(`ACS_ENTRY_BITS - 1))) begin // RQ17
                n.m11_on = 1'b0;
            end
        end
        if (bc == 3'd7) begin
            n.byte_q = {s.shr[6:0], din};
            n.tgl = ~s.tgl;
            if (tx.mode == `ACS_MODE_SER_CLK && s.shr[6] && !s.m11_on) begin // RQ13
                n.m11_on = 1'b1;
                n.m11_tmp = din;
                n.m11c = 8'd0;
            end
        end
    end

    // Conversion state survives chip select so a short pulse keeps it
    always_ff @(posedge sclk or negedge resetn) begin // RQ14
        if (!resetn) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    always_ff @(negedge sclk or negedge resetn) begin
        if (!resetn) begin
            q <= 1'b0;
        end else begin
            q <= pick(s, tx); // RQ24
        end
    end

    always_comb begin
        cp = s;
        cp.txc = 6'd0;
        dout = live ? q : pick(cp, tx); // RQ23
    end

    assign rx = '{rx_byte: s.byte_q, rx_tgl: s.tgl, rx_part: s.shr, rx_count: s.bitc,
                  tx_count: s.txc, frame_tgl: s.ftgl};
endmodule
`default_nettype wire

// >>> hdl/adc_conversion_sequencer.sv
/*
 Conversion sequencer: command decode, clock modes, result FIFO, EOC.
 Assumes adc_result and adc_temp come from the analog core on clk_sys and
 hold their value from the end of a conversion until the next adc_start.
 SCLK, chip select and convert start are pins; SCLK clocks the link.
*/
`timescale 1ns/1ps
`default_nettype none
`include "acs_params.svh"
module adc_conversion_sequencer #(
    parameter int NUM_CH = 16,
    parameter int DEPTH = 16,
    parameter int CONV_CYC = 16
) (
    input wire logic clk_sys, // Internal oscillator
    input wire logic resetn, // Asynchronous reset
    input wire logic sclk, // Serial clock
    input wire logic cs_n, // Chip select
    input wire logic din, // Serial data in
    output logic dout, // Serial data out
    input wire logic convert_start_n, // Conversion start pin
    output logic eoc_n, // End of conversion
    output logic adc_start, // Starts one analog conversion
    output logic [3:0] adc_channel, // Multiplexer channel
    output logic adc_temp_sel, // Temperature conversion
    input wire logic [9:0] adc_result, // Channel result
    input wire logic [11:0] adc_temp, // Temperature result
    output logic [7:0] adc_unipolar, // Unipolar pair selects
    output logic [7:0] adc_bipolar, // Bipolar pair selects
    output logic [1:0] clock_mode_select, // Current clock mode
    output logic [1:0] reference_mode_field // Reference control
);
    localparam int AW = $clog2(DEPTH);

    if (NUM_CH < 1 || NUM_CH > 16 || DEPTH < 2 || DEPTH > 16 || (1 << AW) != DEPTH
        || CONV_CYC < 1 || CONV_CYC > 4095) begin : bad_param
        $error("Unsupported sequencer parameters");
    end

    typedef struct packed {
        logic [2:0] cs_q;
        logic [2:0] cv_q;
        logic [2:0] rx_q;
        logic fseen;
        logic [7:0] setup;
        logic [7:0] conv;
        logic [7:0] avgr;
        logic [7:0] unip;
        logic [7:0] bip;
        logic [1:0] pend;
        logic [DEPTH-1:0][15:0] fifo;
        logic [AW-1:0] rd;
        logic [AW-1:0] wr;
        logic [AW:0] cnt;
        logic [4:0] start_bit;
        acs_pkg::acs_seq_type st;
        logic [3:0] ch;
        logic [4:0] rep;
        logic [5:0] navg;
        logic [14:0] acc;
        logic [11:0] tmr;
        logic eoc_n;
        logic temp_pend;
        logic adc_go;
        logic [15:0] direct;
        logic [15:0] tword;
    } acs_sys_type;

    localparam acs_sys_type SYS_RST = '{cs_q: 3'b111, cv_q: 3'b111, setup: `ACS_SETUP_RESET,
        eoc_n: 1'b1, st: acs_pkg::ACS_IDLE, default: '0}; // RQ22

    acs_sys_type s;
    acs_sys_type n;
    acs_pkg::acs_tx_type tx;
    acs_pkg::acs_rx_type rx;
    logic cs_fall;
    logic cs_rise;
    logic cv_fall;
    logic cv_rise;
    logic rx_ev;
    logic [1:0] mode;
    logic push;
    logic [15:0] pw;
    logic [AW:0] pops;
    logic [6:0] pos;
    logic [7:0] al;
    logic [14:0] sum;
    logic [9:0] nxt;
    logic [5:0] alen;

    acs_serial_link acs_serial_link_inst (
        .sclk(sclk),
        .resetn(resetn),
        .cs_n(cs_n),
        .din(din),
        .dout(dout),
        .tx(tx),
        .rx(rx)
    );

    function automatic acs_pkg::acs_cmd_type cmd_kind(logic [7:0] b);
        if (b[7]) begin
            cmd_kind = acs_pkg::ACS_CMD_CONV;
        end else if (b[6]) begin
            cmd_kind = acs_pkg::ACS_CMD_SETUP;
        end else if (b[5]) begin
            cmd_kind = acs_pkg::ACS_CMD_AVG;
        end else if (b[4]) begin
            cmd_kind = acs_pkg::ACS_CMD_RESET; // RQ1
        end else begin
            cmd_kind = acs_pkg::ACS_CMD_NONE;
        end
    endfunction

    // New bits enter from the MSB downward, the rest keep their old value
    function automatic logic [7:0] merge(logic [7:0] old, logic [7:0] nw, logic [2:0] k);
        logic [7:0] m;
        m = 8'(8'hFF << (4'd8 - {1'b0, k}));
        merge = (nw & m) | (old & ~m); // RQ20
    endfunction

    function automatic logic [3:0] first_ch(logic [7:0] cv);
        first_ch = (cv[`ACS_SCAN] == 2'b00) ? 4'd0 : cv[`ACS_CH];
    endfunction

    // Returns {done, next channel, next repeat count}
    function automatic logic [9:0] scan_next(logic [7:0] cv, logic [7:0] av, logic [3:0] c, logic [4:0] r);
        logic dn;
        logic [4:0] lim;
        dn = 1'b1;
        lim = 5'({av[`ACS_NSCAN], 2'b00}) + 5'd4;
        case (cv[`ACS_SCAN])
            2'b00: dn = (c >= cv[`ACS_CH]);
            2'b01: dn = (c == 4'(NUM_CH - 1));
            2'b10: dn = (r + 5'd1 >= lim);
            default: dn = 1'b1;
        endcase
        if (cv[`ACS_SCAN] == 2'b10) begin
            scan_next = {dn, c, r + 5'd1};
        end else begin
            scan_next = {dn, c + 4'd1, r};
        end
    endfunction

    assign cs_fall = s.cs_q[2] & ~s.cs_q[1];
    assign cs_rise = ~s.cs_q[2] & s.cs_q[1];
    assign cv_fall = s.cv_q[2] & ~s.cv_q[1];
    assign cv_rise = ~s.cv_q[2] & s.cv_q[1];
    assign rx_ev = s.rx_q[2] ^ s.rx_q[1];
    assign mode = s.setup[`ACS_CLOCK_MODE_SELECT];
    assign alen = s.avgr[`ACS_AVGON_BIT] ? 6'(6'd4 << s.avgr[`ACS_NAVG]) : 6'd1;

    always_comb begin
        n = s;
        push = 1'b0;
        pw = 16'h0000;
        pops = '0;
        pos = 7'(s.start_bit) + 7'(rx.tx_count);
        al = 8'(rx.rx_part << (4'd8 - {1'b0, rx.rx_count}));
        sum = s.acc + 15'(adc_result);
        nxt = scan_next(s.conv, s.avgr, s.ch, s.rep);
        n.cs_q = {s.cs_q[1:0], cs_n};
        n.cv_q = {s.cv_q[1:0], convert_start_n};
        n.rx_q = {s.rx_q[1:0], rx.rx_tgl};
        n.adc_go = 1'b0;
        if (s.cs_q[1]) begin
            n.direct = {4'h0, adc_result, 2'b00}; // RQ13
            n.tword = {4'h0, adc_temp}; // RQ23
        end

        // Frame end: retire what was read, apply a cut-short write
        if (cs_rise && rx.frame_tgl != s.fseen) begin
            n.fseen = rx.frame_tgl;
            if (mode != `ACS_MODE_SER_CLK && s.cnt != '0) begin
                pops = (pos >= 7'd32) ? (AW+1)'(2) : (AW+1)'(pos[6:4]);
                n.start_bit = 5'd0;
                if (pos < 7'd32 && pos[3:0] > 4'd8) begin
                    pops = pops + (AW+1)'(1); // RQ19
                end else if (pos < 7'd32 && pos[3:0] != 4'd0) begin
                    n.start_bit = 5'(pos[3:0]); // RQ18
                end
                if (pops >= s.cnt) begin
                    pops = s.cnt;
                    n.start_bit = 5'd0;
                end
            end
            if (rx.rx_count != 3'd0) begin
                if (s.pend == 2'b10) begin
                    n.unip = merge(s.unip, al, rx.rx_count); // RQ20
                end else if (s.pend == 2'b11) begin
                    n.bip = merge(s.bip, al, rx.rx_count);
                end else if (rx.rx_count >= 3'd2 && cmd_kind(al) == acs_pkg::ACS_CMD_SETUP) begin
                    n.setup = merge(s.setup, al, rx.rx_count);
                end else if (rx.rx_count >= 3'd3 && cmd_kind(al) == acs_pkg::ACS_CMD_AVG) begin
                    n.avgr = merge(s.avgr, al, rx.rx_count);
                end
                n.pend = 2'b00;
            end
        end

        // Whole bytes from the link
        if (rx_ev) begin
            if (s.pend[1]) begin
                if (s.pend[0]) begin
                    n.bip = rx.rx_byte;
                end else begin
                    n.unip = rx.rx_byte;
                end
                n.pend = 2'b00;
            end else begin
                case (cmd_kind(rx.rx_byte))
                    acs_pkg::ACS_CMD_CONV: begin
                        n.conv = rx.rx_byte;
                        n.ch = first_ch(rx.rx_byte);
                        n.rep = 5'd0;
                        n.navg = 6'd0;
                        n.acc = 15'd0;
                        n.temp_pend = rx.rx_byte[`ACS_TEMP_BIT]; // RQ11
                        if (mode == `ACS_MODE_SER_SCAN && s.st == acs_pkg::ACS_IDLE) begin
                            n.st = acs_pkg::ACS_WAKE; // RQ12
                            n.tmr = (s.setup[`ACS_REFERENCE_MODE_FIELD] == `ACS_REF_AUTO) ? 12'(`ACS_REF_WAKE_CYC) : 12'd0;
                        end
                    end
                    acs_pkg::ACS_CMD_SETUP: begin
                        n.setup = rx.rx_byte;
                        n.pend = rx.rx_byte[1] ? rx.rx_byte[`ACS_DIFFSEL] : 2'b00;
                    end
                    acs_pkg::ACS_CMD_AVG: begin
                        n.avgr = rx.rx_byte;
                    end
                    default: begin
                    end
                endcase
            end
        end

        // Conversion-start pin triggers
        if (cv_rise && s.st == acs_pkg::ACS_IDLE) begin
            if (mode == `ACS_MODE_CNV_SCAN) begin
                n.st = acs_pkg::ACS_WAKE; // RQ3
                n.ch = first_ch(s.conv);
                n.rep = 5'd0;
                n.navg = 6'd0;
                n.acc = 15'd0;
                n.temp_pend = s.conv[`ACS_TEMP_BIT];
                n.tmr = (s.setup[`ACS_REFERENCE_MODE_FIELD] == `ACS_REF_AUTO) ? 12'(`ACS_REF_WAKE_CYC) : 12'd0;
            end else if (mode == `ACS_MODE_CNV_ONE) begin
                n.st = acs_pkg::ACS_WAKE; // RQ8
                n.tmr = s.temp_pend ? 12'(`ACS_REF_WAKE_CYC) : 12'd0;
            end
        end

        case (s.st)
            acs_pkg::ACS_IDLE: begin
            end
            acs_pkg::ACS_WAKE: begin
                if (s.tmr == 12'd0) begin
                    n.st = acs_pkg::ACS_CONV;
                    n.adc_go = 1'b1;
                    n.tmr = 12'(CONV_CYC - 1);
                end else begin
                    n.tmr = s.tmr - 12'd1;
                end
            end
            acs_pkg::ACS_CONV: begin
                if (s.tmr != 12'd0) begin
                    n.tmr = s.tmr - 12'd1;
                end else begin
                    n.st = (mode == `ACS_MODE_CNV_ONE) ? acs_pkg::ACS_IDLE : acs_pkg::ACS_WAKE;
                    if (s.temp_pend) begin
                        push = 1'b1; // RQ6
                        pw = {4'h0, adc_temp};
                        n.temp_pend = 1'b0;
                    end else if (s.navg + 6'd1 >= alen) begin
                        push = 1'b1; // RQ10
                        pw = {4'h0, 10'(sum >> (s.avgr[`ACS_AVGON_BIT] ? 4'd2 + 4'(s.avgr[`ACS_NAVG]) : 4'd0)), 2'b00};
                        n.acc = 15'd0;
                        n.navg = 6'd0;
                        n.ch = nxt[8:5];
                        n.rep = nxt[4:0];
                        if (nxt[9]) begin
                            n.st = acs_pkg::ACS_IDLE;
                            n.ch = first_ch(s.conv);
                            n.rep = 5'd0;
                        end
                    end else begin
                        n.acc = sum;
                        n.navg = s.navg + 6'd1;
                    end
                    if (n.st == acs_pkg::ACS_IDLE) begin
                        n.eoc_n = 1'b0; // RQ4
                    end
                end
            end
            default: begin
                n.st = acs_pkg::ACS_IDLE;
            end
        endcase

        // EOC returns high on select falling, or start falling in modes 00 and 01; a finish that pushes a result in the same cycle wins
        if ((cs_fall || (cv_fall && mode[1] == 1'b0)) && !(push && n.st == acs_pkg::ACS_IDLE)) begin
            n.eoc_n = 1'b1;
        end

        n.rd = s.rd + pops[AW-1:0]; // RQ25
        n.cnt = s.cnt - pops;
        if (push && n.cnt != (AW+1)'(DEPTH)) begin
            n.fifo[s.wr] = pw;
            n.wr = s.wr + AW'(1);
            n.cnt = n.cnt + (AW+1)'(1);
        end

        if (rx_ev && !s.pend[1] && cmd_kind(rx.rx_byte) == acs_pkg::ACS_CMD_RESET) begin
            n.rd = '0;
            n.wr = '0;
            n.cnt = '0;
            n.start_bit = 5'd0;
            if (!rx.rx_byte[`ACS_RST_FIFO_BIT]) begin // RQ2
                n.setup = `ACS_SETUP_RESET;
                n.conv = `ACS_REG_RESET;
                n.avgr = `ACS_REG_RESET;
                n.unip = `ACS_REG_RESET;
                n.bip = `ACS_REG_RESET;
                n.temp_pend = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            s <= SYS_RST;
        end else begin
            s <= n;
        end
    end

    assign tx = '{word0: (s.cnt != '0) ? s.fifo[s.rd] : 16'h0000,
                  word1: (s.cnt > (AW+1)'(1)) ? s.fifo[s.rd + AW'(1)] : 16'h0000,
                  direct: s.direct, temp: s.tword, start_bit: s.start_bit, mode: mode};
    assign eoc_n = s.eoc_n;
    assign adc_start = s.adc_go;
    assign adc_channel = s.ch;
    assign adc_temp_sel = s.temp_pend;
    assign adc_unipolar = s.unip;
    assign adc_bipolar = s.bip;
    assign clock_mode_select = mode;
    assign reference_mode_field = s.setup[`ACS_REFERENCE_MODE_FIELD];
endmodule
`default_nettype wire

// >>> verification/acs_asserts.sv
/*
 Pin checker of the sequencer, bound into it.
 Assumes SCLK stands still while chip select is high.
*/
`timescale 1ns/1ps
`default_nettype none
module acs_asserts #(parameter int NUM_CH = 16, parameter int DEPTH = 16, parameter int CONV_CYC = 16) (
    input wire logic clk_sys, // Clock
    input wire logic resetn, // Reset
    input wire logic sclk, // Link clock
    input wire logic cs_n, // Select
    input wire logic din, // In
    input wire logic dout, // Out
    input wire logic convert_start_n, // Start
    input wire logic eoc_n, // Done
    input wire logic adc_start, // Pulse
    input wire logic [3:0] adc_channel, // Channel
    input wire logic adc_temp_sel, // Temp
    input wire logic [9:0] adc_result, // Result
    input wire logic [11:0] adc_temp, // Temp result
    input wire logic [7:0] adc_unipolar, // Unipolar
    input wire logic [7:0] adc_bipolar, // Bipolar
    input wire logic [1:0] clock_mode_select, // Mode
    input wire logic [1:0] reference_mode_field // Ref
);
    logic [3:0] quiet;
    logic [7:0] since;
    logic chan_seen;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            quiet <= 4'hF;
            since <= 8'hFF;
            chan_seen <= 1'b0;
        end else begin
            quiet <= !cs_n ? 4'h0 : quiet + {3'h0, quiet != 4'hF};
            since <= adc_start ? 8'h00 : since + {7'h00, since != 8'hFF};
            chan_seen <= eoc_n && (chan_seen || (adc_start && !adc_temp_sel));
        end
    end
    default clocking dc @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    sequence conv_run;
        (!adc_start && $stable(adc_channel)) [*8];
    endsequence
    sequence cs_fall;
        $fell(cs_n);
    endsequence
    reset_values_a: assert property (
        $rose(resetn) |-> eoc_n && clock_mode_select == 2'h2 && reference_mode_field == 2'h0)
        else $error("bad reset value");
    start_idle_a: assert property (adc_start |-> eoc_n) else $error("start while eoc low");
    conv_gap_a: assert property (adc_start |=> conv_run) else $error("start too soon");
    eoc_clear_a: assert property (cs_fall |-> ##[1:6] eoc_n) else $error("eoc not cleared");
    eoc_hold_a: assert property (
        !eoc_n && cs_n && convert_start_n && $past(cs_n, 4) && $past(convert_start_n, 4) |=> !eoc_n)
        else $error("eoc lost");
    eoc_late_a: assert property ($fell(eoc_n) |-> since >= CONV_CYC - 2) else $error("eoc early");
    mode_write_a: assert property (
        $changed({clock_mode_select, reference_mode_field}) |-> quiet < 4'hC)
        else $error("setup changed outside frame");
    temp_first_a: assert property (adc_start && adc_temp_sel |-> !chan_seen) else $error("temp late");
endmodule
bind adc_conversion_sequencer acs_asserts #(.NUM_CH(NUM_CH), .DEPTH(DEPTH), .CONV_CYC(CONV_CYC)) acs_asserts_inst (.*);
`default_nettype wire

// >>> verification/acs_host.sv
/*
 Host model: chip select, SCLK, DIN and convert start.
 Assumes its tasks are called one at a time.
*/
`timescale 1ns/1ps
`default_nettype none
module acs_host (
    output logic sclk, // Link clock
    output logic cs_n, // Select
    output logic din, // Data in
    output logic convert_start_n, // Start
    input wire logic dout // Data out
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        din = 1'b1;
        convert_start_n = 1'b1;
    end
    // SCLK runs only inside a frame, 12 ns period
    task automatic frame(input logic [31:0] tx, input int n, output logic [31:0] rx);
        rx = 32'h0000_0000;
        cs_n = 1'b0;
        #31;
        for (int i = 0; i < n; i++) begin
            din = tx[31 - i];
            #6;
            rx = {rx[30:0], dout};
            sclk = 1'b1;
            #6 sclk = 1'b0;
        end
        #7 cs_n = 1'b1;
        din = ~din;
        #200;
    endtask
    task automatic pulse(input int hold);
        convert_start_n = 1'b0;
        #hold convert_start_n = 1'b1;
        #100;
    endtask
endmodule
`default_nettype wire

// >>> verification/adc_conversion_sequencer_tb.sv
/*
 Testbench of the sequencer with a host model.
 Assumes constant analog results from the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_sequencer_tb;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic [9:0] adc_result = 10'h2A5;
    logic [11:0] adc_temp = 12'hB3C;
    wire sclk, cs_n, din, dout, convert_start_n, eoc_n, adc_start, adc_temp_sel;
    wire [3:0] adc_channel;
    wire [7:0] adc_unipolar, adc_bipolar;
    wire [1:0] clock_mode_select, reference_mode_field;
    wire [15:0] chan_word = {4'h0, adc_result, 2'h0};
    wire [15:0] temp_word = {4'h0, adc_temp};
    int num_errors = 0;
    int checked = 0;
    logic [31:0] rx;
    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end
    adc_conversion_sequencer adc_conversion_sequencer_inst (.clk_sys, .resetn, .sclk, .cs_n, .din,
        .dout, .convert_start_n, .eoc_n, .adc_start, .adc_channel, .adc_temp_sel, .adc_result,
        .adc_temp, .adc_unipolar, .adc_bipolar, .clock_mode_select, .reference_mode_field);
    acs_host acs_host_inst (.sclk, .cs_n, .din, .convert_start_n, .dout);
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic results();
        $display("Compared %0d, mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic wait_eoc(input logic lvl);
        for (int n = 0; eoc_n !== lvl; n++) begin
            @(negedge clk_sys);
            if (n > 20000) begin
                check(eoc_n, lvl, "eoc wait");
                results();
            end
        end
    endtask
    task automatic cmd(input logic [7:0] b, input int n);
        acs_host_inst.frame({b, 24'h00_0000}, n, rx);
    endtask
    task automatic t_reset();
        check(eoc_n, 1'b1, "eoc idle");
        check({clock_mode_select, reference_mode_field}, 4'h8, "setup");
        check({adc_unipolar, adc_bipolar}, 16'h0000, "pair regs");
    endtask
    task automatic t_scan10();
        cmd(8'h68, 8);
        cmd(8'h97, 8);
        wait_eoc(1'b0);
        acs_host_inst.frame(32'h0000_0000, 32, rx);
        check(rx, {temp_word, chan_word}, "scan order");
        check(eoc_n, 1'b1, "eoc release");
    endtask
    task automatic t_partial();
        cmd(8'h94, 8);
        wait_eoc(1'b0);
        acs_host_inst.frame(32'h0000_0000, 12, rx);
        acs_host_inst.frame(32'h0000_0000, 16, rx);
        check(rx, chan_word, "after drop");
        acs_host_inst.frame(32'h0000_0000, 4, rx);
        acs_host_inst.frame(32'h0000_0000, 8, rx);
        check(rx, chan_word[11:4], "next byte");
        cmd(8'h1F, 8);
        acs_host_inst.frame(32'h0000_0000, 16, rx);
        check(rx, 32'h0000_0000, "fifo cleared");
        check(clock_mode_select, 2'h2, "mode kept");
    endtask
    task automatic t_mode00();
        acs_host_inst.frame(32'h4AC3_0000, 16, rx);
        check(adc_unipolar, 8'hC3, "unipolar");
        check(clock_mode_select, 2'h0, "mode 00");
        cmd(8'h96, 8);
        acs_host_inst.pulse(100);
        wait_eoc(1'b0);
        repeat (50) @(negedge clk_sys);
        check(eoc_n, 1'b0, "eoc held");
        acs_host_inst.frame(32'h0000_0000, 16, rx);
        check(rx, chan_word, "mode 00 result");
    endtask
    task automatic t_mode01();
        cmd(8'h58, 8);
        cmd(8'h96, 8);
        acs_host_inst.pulse(1400);
        wait_eoc(1'b0);
        check(adc_channel, 4'h2, "mode 01 channel");
        acs_host_inst.frame(32'h0000_0000, 16, rx);
        check(rx, chan_word, "mode 01 result");
    endtask
    task automatic t_mode11();
        cmd(8'h70, 4);
        check({clock_mode_select, reference_mode_field}, 4'hE, "partial setup");
        acs_host_inst.frame({8'h96, 24'h00_0000}, 24, rx);
        check(rx[15:0], chan_word, "mode 11 result");
        cmd(8'h17, 8);
        check({clock_mode_select, reference_mode_field}, 4'h8, "full reset");
        check(adc_unipolar, 8'h00, "unipolar reset");
    endtask
    initial begin
        repeat (6) @(negedge clk_sys);
        resetn = 1'b1;
        repeat (4) @(negedge clk_sys);
        t_reset();
        t_scan10();
        t_partial();
        t_mode00();
        t_mode01();
        t_mode11();
        results();
    end
endmodule
`default_nettype wire
